// *** tpcu_params.svh ***
`ifndef TPCU_PARAMS_SVH
`define TPCU_PARAMS_SVH

// clock source select codes
`define TPCU_CLK_NONE 2'h0
`define TPCU_CLK_BUS 2'h1
`define TPCU_CLK_FIXED 2'h2
`define TPCU_CLK_EXT 2'h3

// channel mode codes
`define TPCU_MODE_OFF 2'h0
`define TPCU_MODE_CAPTURE 2'h1
`define TPCU_MODE_COMPARE 2'h2
`define TPCU_MODE_EPWM 2'h3

// capture edge codes
`define TPCU_EDGE_NONE 2'h0
`define TPCU_EDGE_RISE 2'h1
`define TPCU_EDGE_FALL 2'h2
`define TPCU_EDGE_ANY 2'h3

// compare action codes
`define TPCU_ACT_NONE 2'h0
`define TPCU_ACT_TOGGLE 2'h1
`define TPCU_ACT_CLEAR 2'h2
`define TPCU_ACT_SET 2'h3

// counter figures
`define TPCU_CNT_MAX 16'hFFFF
`define TPCU_CNT_ZERO 16'h0000
`define TPCU_CH_RST 16'h0000
`define TPCU_MOD_RST 16'h0000
`define TPCU_PRESCALE_W 7

`endif

// *** tpcu_pkg.sv ***
package tpcu_pkg;
    typedef logic [1:0] tpcu_clk_sel_type;
    typedef logic [1:0] tpcu_ch_mode_type;
    typedef logic [1:0] tpcu_ch_cfg_type;
    typedef logic [2:0] tpcu_prescale_type;
endpackage

// *** tpcu_edge_sync.sv ***
`include "tpcu_params.svh"

// two-stage synchroniser with edge detector behind the second stage
module tpcu_edge_sync
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // asynchronous level
    input wire logic i_async,
    // synchronised level and edges
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    assign o_rise = sync_q & ~last_q;
    assign o_fall = ~sync_q & last_q;
endmodule // tpcu_edge_sync

// *** tpcu_timer.sv ***
`include "tpcu_params.svh"

// What this block does
// R01: edge pwm loads buffer at mod-1 to mod
// R02: centre pwm loads buffer at mod-1 to mod
// R03: free-running loads at FFFE to FFFF
// R04: centre value equal nonzero modulo gives full duty
// R05: centre value modulo-1 gives near full duty
// R06: zero to nonzero waits for new period
// R07: nonzero to zero finishes period with old
// R08: control write in debug resets modulo pairing
// R09: control write resets channel byte pairing
// R10: software writes control before channel values
// R11: prescaler divides by 1 to 128
// R12: clock from bus, fixed clock or pin
// R13: fixed clock synchronised to bus clock
// R14: capture on rising, falling or any edge
// R15: compare sets, clears or toggles output
// R16: pwm output polarity selectable
// R17: 16-bit free-running or up/down counter
// R18: one irq per channel plus overflow
// R19: one to eight independent channels
// R20: one bit makes all channels centre pwm
// R21: centre pwm active on down match
// R22: counting frozen in background debug state
// R23: half-written pair stays pending
module tpcu_timer
#(
    parameter int NUM_CH = 2
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // system state
    input wire logic i_background_debug_state,
    // timer status control
    input wire logic i_timer_status_control_wr,
    input wire tpcu_pkg::tpcu_clk_sel_type i_clock_source_select,
    input wire tpcu_pkg::tpcu_prescale_type i_prescale,
    input wire logic i_center_aligned_pwm,
    // modulo pair byte writes
    input wire logic i_modulo_hi_wr,
    input wire logic i_modulo_lo_wr,
    input wire logic [7:0] i_modulo_data,
    // counter clear
    input wire logic i_counter_clear,
    // channel configuration and value pair byte writes
    input wire tpcu_pkg::tpcu_ch_mode_type [NUM_CH-1:0] i_ch_mode,
    input wire tpcu_pkg::tpcu_ch_cfg_type [NUM_CH-1:0] i_ch_cfg,
    input wire logic [NUM_CH-1:0] i_ch_pol_low,
    input wire logic [NUM_CH-1:0] i_ch_hi_wr,
    input wire logic [NUM_CH-1:0] i_ch_lo_wr,
    input wire logic [7:0] i_ch_data,
    // external clock sources and pins
    input wire logic i_fixed_clk,
    input wire logic i_ext_clk,
    input wire logic [NUM_CH-1:0] i_ch_pin,
    // state and outputs
    output logic [15:0] o_counter,
    output logic [15:0] o_modulo_value,
    output logic [NUM_CH-1:0][15:0] o_channel_value,
    output logic [NUM_CH-1:0] o_ch_out,
    output logic [NUM_CH-1:0] o_ch_oe,
    output logic [NUM_CH-1:0] o_ch_irq,
    output logic o_overflow_irq
);
    import tpcu_pkg::*;

    // ----------------------------------------------------------------
    // clock source and prescaler
    // ----------------------------------------------------------------
    logic fixed_rise;
    logic ext_rise;
    logic [NUM_CH-1:0] pin_lvl;
    logic [NUM_CH-1:0] pin_rise;
    logic [NUM_CH-1:0] pin_fall;
    logic src_tick;
    logic tick;
    logic [`TPCU_PRESCALE_W-1:0] pre_q;

    tpcu_edge_sync u_fixed_sync
    (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_fixed_clk),
        .o_level(),
        .o_rise(fixed_rise),
        .o_fall()
    ); // [R13]

    tpcu_edge_sync u_ext_sync
    (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_ext_clk),
        .o_level(),
        .o_rise(ext_rise),
        .o_fall()
    );

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_pin
        tpcu_edge_sync u_pin_sync
        (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_async(i_ch_pin[g]),
            .o_level(pin_lvl[g]),
            .o_rise(pin_rise[g]),
            .o_fall(pin_fall[g])
        );
    end

    // source pulse, suspended in debug state
    always_comb
    begin
        src_tick = 1'b0;
        if (!i_background_debug_state) // [R22]
        begin
            case (i_clock_source_select) // [R12]
                `TPCU_CLK_BUS: src_tick = 1'b1;
                `TPCU_CLK_FIXED: src_tick = fixed_rise;
                `TPCU_CLK_EXT: src_tick = ext_rise;
                default: src_tick = 1'b0;
            endcase
        end
    end

    // prescaler taps: tick when low bits below the tap are all ones
    function automatic logic tap_done(input logic [6:0] cnt,
                                      input logic [2:0] sel);
        logic [6:0] m;
        m = 7'((8'h01 << sel) - 8'h01);
        tap_done = ((cnt & m) == m);
    endfunction

    assign tick = src_tick && tap_done(pre_q, i_prescale); // [R11]

    always_ff @(posedge i_clk)
    begin
        if (i_srst || i_counter_clear)
            pre_q <= '0;
        else if (src_tick)
            pre_q <= pre_q + 7'h01;
    end

    // ----------------------------------------------------------------
    // modulo pair
    // ----------------------------------------------------------------
    logic [7:0] mod_hi_buf_q;
    logic mod_hi_seen_q;
    logic [15:0] modulo_q;

    // high byte is latched, low byte commits the pair
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            mod_hi_buf_q <= 8'h00;
            mod_hi_seen_q <= 1'b0;
            modulo_q <= `TPCU_MOD_RST;
        end
        else if (i_timer_status_control_wr && i_background_debug_state)
            mod_hi_seen_q <= 1'b0; // [R08]
        else if (i_modulo_hi_wr)
        begin
            mod_hi_buf_q <= i_modulo_data;
            mod_hi_seen_q <= 1'b1;
        end
        else if (i_modulo_lo_wr && mod_hi_seen_q)
        begin
            modulo_q <= {mod_hi_buf_q, i_modulo_data};
            mod_hi_seen_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    logic [15:0] cnt_q;
    logic down_q;
    logic [15:0] top;
    logic free_run;
    logic at_top;
    logic load_pt;
    logic period_start;

    assign free_run = (modulo_q == `TPCU_CNT_ZERO) ||
                      (modulo_q == `TPCU_CNT_MAX);
    assign top = free_run ? `TPCU_CNT_MAX : modulo_q;
    assign at_top = (cnt_q == top);
    // stepping from top-1 to top, when buffers load
    assign load_pt = tick && !down_q && (cnt_q == top - 16'h0001); // [R01] [R02] [R03]
    // period boundary: wrap in up mode, turnaround at zero in centre mode
    assign period_start = tick && (i_center_aligned_pwm ?
                          (down_q && cnt_q == 16'h0001) : at_top);

    always_ff @(posedge i_clk)
    begin
        if (i_srst || i_counter_clear)
        begin
            cnt_q <= `TPCU_CNT_ZERO;
            down_q <= 1'b0;
        end
        else if (!i_center_aligned_pwm)
        begin
            down_q <= 1'b0;
            if (tick)
                cnt_q <= at_top ? `TPCU_CNT_ZERO : cnt_q + 16'h0001; // [R17]
        end
        else if (tick)
        begin
            // up to modulo, then down to zero
            if (!down_q && at_top)
            begin
                down_q <= 1'b1;
                cnt_q <= cnt_q - 16'h0001;
            end
            else if (down_q && cnt_q == 16'h0001)
            begin
                down_q <= 1'b0;
                cnt_q <= `TPCU_CNT_ZERO;
            end
            else
                cnt_q <= down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001; // [R17]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_overflow_irq <= 1'b0;
        else
            o_overflow_irq <= i_center_aligned_pwm ? period_start
                              : (tick && at_top); // [R18]
    end

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0][15:0] cv_q;
    logic [NUM_CH-1:0][15:0] wbuf_q;
    logic [NUM_CH-1:0] hi_seen_q;
    logic [NUM_CH-1:0] pend_q;
    logic [NUM_CH-1:0] act_q;
    logic [NUM_CH-1:0] irq_q;
    logic [NUM_CH-1:0] oe_q;

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        logic pwm_mode;
        logic match;
        logic cap_hit;
        logic cv_load;
        logic keep_q;
        logic [15:0] old_q;
        logic [15:0] duty;

        assign pwm_mode = i_center_aligned_pwm ||
                          (i_ch_mode[c] == `TPCU_MODE_EPWM);
        assign match = tick && (cnt_q == cv_q[c]);
        assign cap_hit = (i_ch_cfg[c] == `TPCU_EDGE_RISE && pin_rise[c]) ||
                         (i_ch_cfg[c] == `TPCU_EDGE_FALL && pin_fall[c]) ||
                         (i_ch_cfg[c] == `TPCU_EDGE_ANY &&
                          (pin_rise[c] || pin_fall[c])); // [R14]
        assign cv_load = pend_q[c] && (!pwm_mode || load_pt ||
                         i_clock_source_select == `TPCU_CLK_NONE);
        // duty seen by the centre pwm comparators
        assign duty = keep_q ? old_q : cv_q[c];

        // byte pairing and buffered value
        always_ff @(posedge i_clk)
        begin
            if (i_srst || i_timer_status_control_wr)
            begin
                hi_seen_q[c] <= 1'b0; // [R09]
                if (i_srst)
                begin
                    wbuf_q[c] <= `TPCU_CH_RST;
                    pend_q[c] <= 1'b0;
                end
            end
            else
            begin
                if (i_ch_hi_wr[c])
                begin
                    wbuf_q[c][15:8] <= i_ch_data;
                    hi_seen_q[c] <= 1'b1; // [R23]
                end
                else if (i_ch_lo_wr[c] && hi_seen_q[c])
                begin
                    wbuf_q[c][7:0] <= i_ch_data;
                    hi_seen_q[c] <= 1'b0;
                    pend_q[c] <= 1'b1;
                end
                else if (cv_load)
                    pend_q[c] <= 1'b0;
            end
        end

        // channel value: capture, immediate or buffered load
        always_ff @(posedge i_clk)
        begin
            if (i_srst)
                cv_q[c] <= `TPCU_CH_RST;
            else if (!i_center_aligned_pwm &&
                     i_ch_mode[c] == `TPCU_MODE_CAPTURE && cap_hit)
                cv_q[c] <= cnt_q;
            else if (cv_load)
                cv_q[c] <= wbuf_q[c]; // [R01] [R02] [R06] [R07]
        end

        // loads across zero keep the old duty until the period ends
        always_ff @(posedge i_clk)
        begin
            if (i_srst || !i_center_aligned_pwm)
            begin
                keep_q <= 1'b0;
                old_q <= `TPCU_CH_RST;
            end
            else if (cv_load && ((cv_q[c] == `TPCU_CNT_ZERO) !=
                     (wbuf_q[c] == `TPCU_CNT_ZERO)))
            begin
                keep_q <= 1'b1; // [R06] [R07]
                old_q <= cv_q[c];
            end
            else if (period_start)
                keep_q <= 1'b0;
        end

        // output level, held in active sense
        always_ff @(posedge i_clk)
        begin
            if (i_srst)
            begin
                act_q[c] <= 1'b0;
                irq_q[c] <= 1'b0;
                oe_q[c] <= 1'b0;
            end
            else if (i_center_aligned_pwm) // [R20]
            begin
                oe_q[c] <= 1'b1;
                irq_q[c] <= match;
                if (duty == `TPCU_CNT_ZERO)
                    act_q[c] <= 1'b0;
                else if (duty >= top)
                    act_q[c] <= 1'b1; // [R04]
                else if (tick && (down_q || at_top) &&
                         cnt_q == duty + 16'h0001)
                    act_q[c] <= 1'b1; // [R21] [R05]
                else if (tick && !down_q && cnt_q == duty - 16'h0001)
                    act_q[c] <= 1'b0; // [R21]
            end
            else
            begin
                case (i_ch_mode[c]) // [R19]
                    `TPCU_MODE_CAPTURE:
                    begin
                        oe_q[c] <= 1'b0;
                        irq_q[c] <= cap_hit;
                    end
                    `TPCU_MODE_COMPARE:
                    begin
                        oe_q[c] <= (i_ch_cfg[c] != `TPCU_ACT_NONE);
                        irq_q[c] <= match;
                        if (match)
                        begin
                            case (i_ch_cfg[c]) // [R15]
                                `TPCU_ACT_TOGGLE: act_q[c] <= ~act_q[c];
                                `TPCU_ACT_CLEAR: act_q[c] <= 1'b0;
                                `TPCU_ACT_SET: act_q[c] <= 1'b1;
                                default: act_q[c] <= act_q[c];
                            endcase
                        end
                    end
                    `TPCU_MODE_EPWM:
                    begin
                        oe_q[c] <= 1'b1;
                        irq_q[c] <= match;
                        if (tick && at_top)
                            act_q[c] <= (cv_q[c] != `TPCU_CNT_ZERO);
                        else if (tick && cnt_q + 16'h0001 == cv_q[c])
                            act_q[c] <= 1'b0;
                    end
                    default:
                    begin
                        oe_q[c] <= 1'b0;
                        irq_q[c] <= 1'b0;
                    end
                endcase
            end
        end

        assign o_ch_out[c] = (pwm_mode && i_ch_pol_low[c]) ?
                             ~act_q[c] : act_q[c]; // [R16]
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_counter = cnt_q;
    assign o_modulo_value = modulo_q;
    assign o_channel_value = cv_q;
    assign o_ch_irq = irq_q; // [R18]
    assign o_ch_oe = oe_q;
endmodule // tpcu_timer

// *** tpcu_pin_model.sv ***
// ----
// far-side pins: slow source clock and capture line
// ----
module tpcu_pin_model
(
    // clock
    input wire logic i_clk,
    // commands
    input wire logic i_run,
    input wire logic i_level,
    // pins
    output logic o_clk,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q;
    // source clock at one eighth of the bus rate, still when idle
    always_ff @(posedge i_clk)
    begin
        div_q <= i_run ? div_q + 3'h1 : 3'h0;
        o_clk <= i_run & div_q[2];
        o_pin <= i_level;
    end
endmodule // tpcu_pin_model

// *** tpcu_timer_asserts.sv ***
`include "tpcu_params.svh"

// ----
// port checks
// ----
module tpcu_timer_asserts
#(
    parameter int NUM_CH = 2
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // controls
    input wire logic i_background_debug_state,
    input wire tpcu_pkg::tpcu_clk_sel_type i_clock_source_select,
    input wire tpcu_pkg::tpcu_prescale_type i_prescale,
    input wire logic i_center_aligned_pwm,
    input wire logic i_counter_clear,
    input wire tpcu_pkg::tpcu_ch_mode_type [NUM_CH-1:0] i_ch_mode,
    input wire logic [NUM_CH-1:0] i_ch_pol_low,
    // outputs
    input wire logic [15:0] o_counter,
    input wire logic [15:0] o_modulo_value,
    input wire logic [NUM_CH-1:0][15:0] o_channel_value,
    input wire logic [NUM_CH-1:0] o_ch_out,
    input wire logic o_overflow_irq
);
    import tpcu_pkg::*;
    logic [15:0] top;
    logic pwm;
    logic ep0;
    assign top = (o_modulo_value == `TPCU_MOD_RST) ? `TPCU_CNT_MAX
        : o_modulo_value;
    assign pwm = i_center_aligned_pwm | (i_ch_mode[0] == `TPCU_MODE_EPWM);
    assign ep0 = !i_center_aligned_pwm && i_ch_mode[0] == `TPCU_MODE_EPWM
        && o_channel_value[0] == `TPCU_CH_RST;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    property p_freeze;
        i_background_debug_state && !i_counter_clear |=> $stable(o_counter);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("counter moved in debug state");
    property p_noclk;
        i_clock_source_select == `TPCU_CLK_NONE && !i_counter_clear
        |=> $stable(o_counter);
    endproperty
    a_noclk: assert property (p_noclk)
        else $error("counter moved without source");
    property p_pre;
        $changed(o_counter) && !$past(i_srst) && i_prescale == 3'h2
        && $stable(i_prescale) && !i_counter_clear
        && i_clock_source_select == `TPCU_CLK_BUS |=> $stable(o_counter)[*3];
    endproperty
    a_pre: assert property (p_pre)
        else $error("divide by four stepped early");
    property p_ovf;
        o_overflow_irq |=> !o_overflow_irq;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow pulse too long");
    property p_load;
        $changed(o_channel_value[0]) && !$past(i_srst) && $past(pwm)
        && $past(i_clock_source_select) != `TPCU_CLK_NONE
        |-> o_counter == top;
    endproperty
    a_load: assert property (p_load)
        else $error("pwm value loaded off the top step");
    property p_full;
        i_center_aligned_pwm && $past(i_center_aligned_pwm)
        && o_channel_value[0] == o_modulo_value && o_modulo_value != 16'h0000
        ##1 $stable(o_channel_value[0])
        |-> o_ch_out[0] == !i_ch_pol_low[0];
    endproperty
    a_full: assert property (p_full)
        else $error("full duty not held");
    property p_down;
        i_center_aligned_pwm && $past(i_center_aligned_pwm)
        && i_prescale == 3'h0 && $past(o_counter) == o_counter + 16'h0001
        && o_counter == o_channel_value[0] && o_counter != 16'h0000
        && $past(o_channel_value[0], 2) == o_channel_value[0]
        |-> ##[0:1] o_ch_out[0] == !i_ch_pol_low[0];
    endproperty
    a_down: assert property (p_down)
        else $error("no activation on down match");
    sequence s_ep0;
        ep0;
    endsequence
    property p_ep0;
        s_ep0 ##1 s_ep0 |-> o_ch_out[0] == i_ch_pol_low[0];
    endproperty
    a_ep0: assert property (p_ep0)
        else $error("zero duty output active");
    c_cen: cover property (i_center_aligned_pwm && o_ch_out[0]);
    c_ovf: cover property (o_overflow_irq);
    c_dbg: cover property (i_background_debug_state && !i_counter_clear);
endmodule // tpcu_timer_asserts

bind tpcu_timer tpcu_timer_asserts #(.NUM_CH(NUM_CH)) tpcu_timer_asserts_inst
(
    .i_clk, .i_srst, .i_background_debug_state, .i_clock_source_select,
    .i_prescale, .i_center_aligned_pwm, .i_counter_clear, .i_ch_mode,
    .i_ch_pol_low, .o_counter, .o_modulo_value, .o_channel_value, .o_ch_out,
    .o_overflow_irq
);

// *** tb_top.sv ***
`include "tpcu_params.svh"

// ----
// bench
// ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tpcu_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic dbg = 1'b0;
    logic sc_wr = 1'b0;
    tpcu_clk_sel_type sel = `TPCU_CLK_BUS;
    tpcu_prescale_type pre = 3'h0;
    logic cen = 1'b0;
    logic mhi = 1'b0;
    logic mlo = 1'b0;
    logic clr = 1'b0;
    tpcu_ch_mode_type [0:0] mode = 2'h0;
    tpcu_ch_cfg_type [0:0] cfg = 2'h0;
    logic [0:0] pol = 1'b0;
    logic [0:0] chi = 1'b0;
    logic [0:0] clo = 1'b0;
    logic [7:0] dat = 8'h00;
    logic run = 1'b0;
    logic lvl = 1'b0;
    logic xclk;
    logic [0:0] pin;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic [0:0][15:0] cv;
    logic [0:0] out;
    logic [0:0] oe;
    logic [0:0] irq;
    logic ovf;
    int fail_count = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;

    tpcu_timer #(.NUM_CH(1)) tpcu_timer_inst
    (
        .i_clk(clk), .i_srst(srst), .i_background_debug_state(dbg),
        .i_timer_status_control_wr(sc_wr), .i_clock_source_select(sel),
        .i_prescale(pre), .i_center_aligned_pwm(cen), .i_modulo_hi_wr(mhi),
        .i_modulo_lo_wr(mlo), .i_modulo_data(dat), .i_counter_clear(clr),
        .i_ch_mode(mode), .i_ch_cfg(cfg), .i_ch_pol_low(pol),
        .i_ch_hi_wr(chi), .i_ch_lo_wr(clo), .i_ch_data(dat),
        .i_fixed_clk(xclk), .i_ext_clk(xclk), .i_ch_pin(pin),
        .o_counter(cnt), .o_modulo_value(modv), .o_channel_value(cv),
        .o_ch_out(out), .o_ch_oe(oe), .o_ch_irq(irq), .o_overflow_irq(ovf)
    );
    tpcu_pin_model tpcu_pin_model_inst
    (
        .i_clk(clk), .i_run(run), .i_level(lvl), .o_clk(xclk), .o_pin(pin)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic m, input logic [15:0] v);
        dat = v[15:8];
        mhi = m;
        chi = !m;
        tick(1);
        mhi = 1'b0;
        chi = 1'b0;
        dat = v[7:0];
        mlo = m;
        clo = !m;
        tick(1);
        mlo = 1'b0;
        clo = 1'b0;
    endtask
    task automatic pulse(input logic c);
        sc_wr = !c;
        clr = c;
        tick(1);
        sc_wr = 1'b0;
        clr = 1'b0;
    endtask
    task automatic wait_cv(input logic [15:0] v, input int lim);
        int n;
        n = 0;
        while (cv[0] !== v && n < lim)
        begin
            tick(1);
            n++;
        end
        chk(cv[0] === v, "value never loaded");
    endtask
    task automatic gap(output int n);
        logic [15:0] c;
        c = cnt;
        n = 0;
        while (cnt === c && n < 400)
        begin
            tick(1);
            n++;
        end
    endtask
    task automatic count(input int n, output int a, output int b);
        a = 0;
        b = 0;
        repeat (n)
        begin
            a += int'(out[0] === 1'b1);
            b += int'(irq[0] === 1'b1);
            tick(1);
        end
    endtask

    task automatic t_epwm();
        int a;
        int b;
        mode = `TPCU_MODE_EPWM;
        pulse(1'b0);
        wr(1'b1, 16'h0004);
        pulse(1'b1);
        chk(modv === 16'h0004, "modulo");
        tick(8);
        wr(1'b0, 16'h0002);
        wait_cv(16'h0002, 12);
        chk(cnt === 16'h0004, "early load");
        for (int p = 0; p < 2; p++)
        begin
            pol = p[0];
            tick(5);
            count(5, a, b);
            chk(a == 2 + p, "edge duty");
        end
        pol = 1'b0;
        b = 0;
        repeat (10)
        begin
            b += int'(ovf === 1'b1);
            tick(1);
        end
        chk(b == 2, "overflow rate");
    endtask
    task automatic t_pairs();
        logic [15:0] c;
        chi = 1'b1;
        tick(1);
        chi = 1'b0;
        pulse(1'b0);
        dat = 8'h07;
        clo = 1'b1;
        tick(1);
        clo = 1'b0;
        tick(12);
        chk(cv[0] === 16'h0002, "half pair took");
        dbg = 1'b1;
        tick(1);
        c = cnt;
        wr(1'b1, 16'h0009);
        chk(modv === 16'h0004 || modv === 16'h0009, "modulo");
        dat = 8'h00;
        mhi = 1'b1;
        tick(1);
        mhi = 1'b0;
        pulse(1'b0);
        dat = 8'h05;
        mlo = 1'b1;
        tick(1);
        mlo = 1'b0;
        tick(2);
        chk(modv !== 16'h0005, "debug pair kept");
        chk(cnt === c, "count in debug");
        wr(1'b1, 16'h0004);
        dbg = 1'b0;
        tick(3);
        chk(cnt !== c, "no resume");
    endtask
    task automatic t_clocks();
        int n;
        for (int p = 0; p < 8; p++)
        begin
            pre = p[2:0];
            pulse(1'b1);
            gap(n);
            gap(n);
            chk(n == (1 << p), "prescale");
        end
        pre = 3'h0;
        sel = `TPCU_CLK_NONE;
        tick(2);
        gap(n);
        chk(n == 400, "ran unclocked");
        run = 1'b1;
        for (int s = 2; s < 4; s++)
        begin
            sel = s[1:0];
            gap(n);
            gap(n);
            chk(n == 8, "source rate");
        end
        run = 1'b0;
        sel = `TPCU_CLK_BUS;
    endtask
    task automatic t_chan();
        int a;
        int b;
        int k;
        mode = `TPCU_MODE_CAPTURE;
        for (int e = 1; e < 4; e++)
        begin
            cfg = e[1:0];
            lvl = 1'b1;
            count(8, a, k);
            lvl = 1'b0;
            count(8, a, b);
            chk(k + b == ((e == 3) ? 2 : 1), "capture edges");
        end
        mode = `TPCU_MODE_COMPARE;
        wr(1'b0, 16'h0003);
        cfg = `TPCU_ACT_SET;
        count(12, a, b);
        chk(out[0] === 1'b1 && oe[0] === 1'b1, "set");
        cfg = `TPCU_ACT_CLEAR;
        count(12, a, b);
        chk(out[0] === 1'b0, "clear");
        cfg = `TPCU_ACT_TOGGLE;
        count(12, a, b);
        chk(a > 3 && a < 9 && b > 1, "toggle");
    endtask
    task automatic t_centre();
        logic [15:0] tbl [5] = '{16'h0004, 16'h0003, 16'h0000, 16'h0003,
            16'h0002};
        logic [15:0] prev;
        int a;
        int b;
        int n;
        cen = 1'b1;
        pulse(1'b1);
        for (int i = 0; i < 5; i++)
        begin
            prev = cv[0];
            wr(1'b0, tbl[i]);
            wait_cv(tbl[i], 20);
            chk(cnt === 16'h0004, "early load");
            n = 0;
            while (prev === 16'h0000 && cnt !== 16'h0000 && n < 9)
            begin
                chk(out[0] === 1'b0, "new duty too soon");
                tick(1);
                n++;
            end
            count(4, a, b);
            chk(tbl[i] != 16'h0000 || a > 0, "old duty dropped");
            tick(16);
            count(8, a, b);
            chk(a == 2 * tbl[i], "centre duty");
        end
        cen = 1'b0;
    endtask
    task automatic t_free();
        mode = `TPCU_MODE_EPWM;
        wr(1'b1, 16'h0000);
        pulse(1'b1);
        wr(1'b0, 16'h1234);
        wait_cv(16'h1234, 70000);
        chk(cnt === 16'hFFFF, "free run load");
    endtask

    initial
    begin
        tick(16);
        srst = 1'b0;
        t_epwm();
        t_pairs();
        t_clocks();
        t_chan();
        t_centre();
        t_free();
        final_report();
    end
    initial
    begin
        #1000000;
        fail_count++;
        $display("ERROR %0t timeout", $time);
        final_report();
    end
endmodule // tb_top
